// ### klsup_pkg.sv
// ----------------------------------------------------------------------------
// Notes on behaviour
// - Each cycle compare knock level with retard threshold; flag detonation when reached.
// - While level is at or above threshold, retard rises by the gain setting.
// - Below threshold, retard falls by the fall rate setting.
// - Retard value never exceeds the configured ceiling.
// - Retard at ceiling and still knocking raises the derate request.
// - Derate request drops as soon as knocking stops.
// - After derate release, retard is held for the hold period before falling.
// - Emergency stop asserts when level strictly exceeds the stop threshold.
// - Measurements count only inside the combustion window; others are ignored.
// - Only self-ignition after the ignition event is evaluated, never pre-ignition.
// - Two- and four-stroke, up to 20 cylinders, sync rate at most 1 kHz.
// - Channel count is a parameter, 2 or up to 20, in firing order.
// ----------------------------------------------------------------------------
package klsup_pkg;

  // --------------------------------------------------------------------------
  // Timing
  // --------------------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 10;
  localparam int MIN_SYNC_NS = 1000000;
  localparam int MIN_SYNC_CYC = (MIN_SYNC_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int MAX_CH = 20;

  // --------------------------------------------------------------------------
  // Register offsets
  // --------------------------------------------------------------------------
  localparam logic [5:0] OFF_RETARD_THR = 6'h00;
  localparam logic [5:0] OFF_STOP_THR = 6'h04;
  localparam logic [5:0] OFF_GAIN = 6'h08;
  localparam logic [5:0] OFF_FALL = 6'h0C;
  localparam logic [5:0] OFF_CEIL = 6'h10;
  localparam logic [5:0] OFF_HOLD = 6'h14;
  localparam logic [5:0] OFF_WIN_DELAY = 6'h18;
  localparam logic [5:0] OFF_WIN_LEN = 6'h1C;
  localparam logic [5:0] OFF_CH_EN = 6'h20;
  localparam logic [5:0] OFF_RETARD = 6'h24;
  localparam logic [5:0] OFF_FLAGS = 6'h28;
  localparam logic [5:0] OFF_LEVEL = 6'h2C;
  localparam logic [5:0] OFF_IRQ_STATUS = 6'h30;
  localparam logic [5:0] OFF_IRQ_MASK = 6'h34;

  // --------------------------------------------------------------------------
  // Reset values
  // --------------------------------------------------------------------------
  localparam logic [15:0] RST_RETARD_THR = 16'h8000;
  localparam logic [15:0] RST_STOP_THR = 16'hC000;
  localparam logic [15:0] RST_GAIN = 16'h0010;
  localparam logic [15:0] RST_FALL = 16'h0004;
  localparam logic [15:0] RST_CEIL = 16'h1000;
  localparam logic [15:0] RST_HOLD = 16'h0010;
  localparam logic [15:0] RST_WIN_DELAY = 16'h0000;
  localparam logic [15:0] RST_WIN_LEN = 16'h0100;
  localparam logic [19:0] RST_CH_EN = 20'hF_FFFF;

  // --------------------------------------------------------------------------
  // Field positions
  // --------------------------------------------------------------------------
  localparam int FLG_DETONATION = 0;
  localparam int FLG_DERATE = 1;
  localparam int FLG_STOP = 2;
  localparam int FLG_STARTED = 3;
  localparam int FLG_HOLDING = 4;
  localparam int IRQ_KNOCK = 0;
  localparam int IRQ_DERATE = 1;
  localparam int IRQ_STOP = 2;
  localparam int IRQ_SYNC_FAST = 3;

  // --------------------------------------------------------------------------
  // Types
  // --------------------------------------------------------------------------
  typedef struct packed {
    logic valid;
    logic [4:0] channel;
    logic [15:0] level;
  } klsup_meas_s;

  typedef struct packed {
    logic detonation;
    logic derate;
    logic stop;
  } klsup_bin_s;

  typedef struct packed {
    logic [15:0] retard_thr;
    logic [15:0] stop_thr;
    logic [15:0] gain;
    logic [15:0] fall;
    logic [15:0] ceil;
    logic [15:0] hold;
    logic [15:0] win_delay;
    logic [15:0] win_len;
    logic [19:0] ch_en;
  } klsup_cfg_s;

  typedef struct packed {
    klsup_cfg_s cfg;
    klsup_bin_s flags;
    logic started;
    logic [15:0] retard;
    logic [15:0] hold_cnt;
    logic [16:0] sync_cnt;
    logic [15:0] win_cnt;
    logic [15:0] last_level;
    logic [3:0] irq_status;
    logic [3:0] irq_mask;
    logic ack;
    logic [31:0] rdata;
  } klsup_state_s;

  typedef struct packed {
    logic [15:0] peak;
  } klsup_peak_s;

  // Byte-lane write merge
  function automatic logic [31:0] klsup_merge(input logic [31:0] old_v,
                                              input logic [31:0] new_v,
                                              input logic [3:0] be);
    logic [31:0] r;
    r = old_v;
    for (int i = 0; i < 4; i++)
    begin
      if (be[i])
        r[i*8 +: 8] = new_v[i*8 +: 8];
    end
    return r;
  endfunction

endpackage

// ### klsup_peak.sv
`timescale 1ns/1ps
module klsup_peak
  import klsup_pkg::*;
#(
  parameter int NUM_CH = MAX_CH
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic clear,
  input wire logic win_open,
  input klsup_meas_s meas,
  input wire logic [19:0] ch_en,
  output logic [15:0] peak
);

  klsup_peak_s s_reg;
  klsup_peak_s s_next;
  logic [NUM_CH-1:0] ch_hit;
  logic accept;

  // --------------------------------------------------------------------------
  // Channel match
  // --------------------------------------------------------------------------
  generate
    for (genvar i = 0; i < NUM_CH; i++)
    begin : g_ch
      assign ch_hit[i] = (meas.channel == 5'(i)) && ch_en[i];
    end
  endgenerate

  assign accept = meas.valid && win_open && (|ch_hit);

  always_comb
  begin
    s_next = s_reg;
    if (clear)
      s_next.peak = 16'h0000;
    else if (accept && meas.level > s_reg.peak)
      s_next.peak = meas.level;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
      s_reg <= '0;
    else
      s_reg <= s_next;
  end

  assign peak = s_reg.peak;

  property p_ignore_outside;
    @(posedge clk) disable iff (!reset_n)
      (!accept && !clear) |=> $stable(peak);
  endproperty
  a_ignore_outside: assert property (p_ignore_outside)
    else $error("Peak changed without an accepted sample");

endmodule // klsup_peak

// ### klsup_top.sv
// The Avalon-MM interface to the registers and the register offsets were decided locally.
`timescale 1ns/1ps
module klsup_top
  import klsup_pkg::*;
#(
  parameter int NUM_CH = MAX_CH,
  parameter logic [16:0] MIN_SYNC_CYCLES = 17'(MIN_SYNC_CYC)
)
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [5:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic sync_pulse,
  input klsup_meas_s meas,
  output logic detonation_flag,
  output logic derate_request,
  output logic emergency_stop_flag,
  output logic [15:0] retard_value,
  output logic irq
);

  klsup_state_s s_reg;
  klsup_state_s s_next;
  logic [15:0] peak;
  logic win_open;
  logic sync_ok;
  logic eval;
  logic knock;
  logic stop_hit;
  logic at_ceil;
  logic req;
  logic wr_fire;
  logic [16:0] win_end;
  logic [16:0] rise_sum;

  // --------------------------------------------------------------------------
  // Window and sync qualification
  // --------------------------------------------------------------------------
  assign win_end = {1'b0, s_reg.cfg.win_delay} + {1'b0, s_reg.cfg.win_len};
  assign win_open = s_reg.started && (s_reg.win_cnt >= s_reg.cfg.win_delay)
                    && ({1'b0, s_reg.win_cnt} < win_end);
  assign sync_ok = sync_pulse
                   && (!s_reg.started || s_reg.sync_cnt >= MIN_SYNC_CYCLES - 17'd1);
  assign eval = sync_ok && s_reg.started;
  assign knock = peak >= s_reg.cfg.retard_thr;
  assign stop_hit = peak > s_reg.cfg.stop_thr;
  assign at_ceil = s_reg.retard >= s_reg.cfg.ceil;
  assign rise_sum = {1'b0, s_reg.retard} + {1'b0, s_reg.cfg.gain};
  assign req = avs_read || avs_write;
  assign wr_fire = avs_write && s_reg.ack;

  klsup_peak #(
    .NUM_CH(NUM_CH)
  ) u_peak (
    .clk(clk),
    .reset_n(reset_n),
    .clear(sync_ok),
    .win_open(win_open),
    .meas(meas),
    .ch_en(s_reg.cfg.ch_en),
    .peak(peak)
  );

  // --------------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------------
  always_comb
  begin
    logic [16:0] ret;
    logic [31:0] wv;
    logic [3:0] clr;
    logic [3:0] ev;
    s_next = s_reg;
    ret = {1'b0, s_reg.retard};
    wv = 32'h0000_0000;
    clr = 4'h0;
    ev = 4'h0;

    // Bus handshake and read data
    s_next.ack = req && !s_reg.ack;
    if (req && !s_reg.ack)
    begin
      unique case (avs_address)
        OFF_RETARD_THR: s_next.rdata = {16'h0000, s_reg.cfg.retard_thr};
        OFF_STOP_THR: s_next.rdata = {16'h0000, s_reg.cfg.stop_thr};
        OFF_GAIN: s_next.rdata = {16'h0000, s_reg.cfg.gain};
        OFF_FALL: s_next.rdata = {16'h0000, s_reg.cfg.fall};
        OFF_CEIL: s_next.rdata = {16'h0000, s_reg.cfg.ceil};
        OFF_HOLD: s_next.rdata = {16'h0000, s_reg.cfg.hold};
        OFF_WIN_DELAY: s_next.rdata = {16'h0000, s_reg.cfg.win_delay};
        OFF_WIN_LEN: s_next.rdata = {16'h0000, s_reg.cfg.win_len};
        OFF_CH_EN: s_next.rdata = {12'h000, s_reg.cfg.ch_en};
        OFF_RETARD: s_next.rdata = {16'h0000, s_reg.retard};
        OFF_FLAGS: s_next.rdata = {27'h000_0000, (s_reg.hold_cnt != 16'h0000),
                                   s_reg.started, s_reg.flags.stop,
                                   s_reg.flags.derate, s_reg.flags.detonation};
        OFF_LEVEL: s_next.rdata = {16'h0000, s_reg.last_level};
        OFF_IRQ_STATUS: s_next.rdata = {28'h000_0000, s_reg.irq_status};
        OFF_IRQ_MASK: s_next.rdata = {28'h000_0000, s_reg.irq_mask};
        default: s_next.rdata = 32'h0000_0000;
      endcase
    end

    // Register writes
    if (wr_fire)
    begin
      unique case (avs_address)
        OFF_RETARD_THR:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.retard_thr}, avs_writedata, avs_byteenable);
          s_next.cfg.retard_thr = wv[15:0];
        end
        OFF_STOP_THR:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.stop_thr}, avs_writedata, avs_byteenable);
          s_next.cfg.stop_thr = wv[15:0];
        end
        OFF_GAIN:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.gain}, avs_writedata, avs_byteenable);
          s_next.cfg.gain = wv[15:0];
        end
        OFF_FALL:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.fall}, avs_writedata, avs_byteenable);
          s_next.cfg.fall = wv[15:0];
        end
        OFF_CEIL:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.ceil}, avs_writedata, avs_byteenable);
          s_next.cfg.ceil = wv[15:0];
        end
        OFF_HOLD:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.hold}, avs_writedata, avs_byteenable);
          s_next.cfg.hold = wv[15:0];
        end
        OFF_WIN_DELAY:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.win_delay}, avs_writedata, avs_byteenable);
          s_next.cfg.win_delay = wv[15:0];
        end
        OFF_WIN_LEN:
        begin
          wv = klsup_merge({16'h0000, s_reg.cfg.win_len}, avs_writedata, avs_byteenable);
          s_next.cfg.win_len = wv[15:0];
        end
        OFF_CH_EN:
        begin
          wv = klsup_merge({12'h000, s_reg.cfg.ch_en}, avs_writedata, avs_byteenable);
          s_next.cfg.ch_en = wv[19:0];
        end
        OFF_IRQ_STATUS:
        begin
          if (avs_byteenable[0])
            clr = avs_writedata[3:0];
        end
        OFF_IRQ_MASK:
        begin
          if (avs_byteenable[0])
            s_next.irq_mask = avs_writedata[3:0];
        end
        default:
        begin
        end
      endcase
    end

    // Cycle reference and window counters
    if (sync_ok)
    begin
      s_next.started = 1'b1;
      s_next.sync_cnt = 17'h0_0000;
      s_next.win_cnt = 16'h0000;
    end
    else
    begin
      if (s_reg.sync_cnt != 17'h1_FFFF)
        s_next.sync_cnt = s_reg.sync_cnt + 17'h0_0001;
      if (s_reg.win_cnt != 16'hFFFF)
        s_next.win_cnt = s_reg.win_cnt + 16'h0001;
    end

    // Per-cycle evaluation
    if (eval)
    begin
      s_next.last_level = peak;
      s_next.flags.stop = stop_hit;
      if (knock)
      begin
        s_next.flags.detonation = 1'b1;
        s_next.flags.derate = at_ceil;
        s_next.hold_cnt = 16'h0000;
        ret = rise_sum;
      end
      else
      begin
        s_next.flags.detonation = 1'b0;
        s_next.flags.derate = 1'b0;
        if (s_reg.flags.derate)
          s_next.hold_cnt = s_reg.cfg.hold;
        else if (s_reg.hold_cnt != 16'h0000)
          s_next.hold_cnt = s_reg.hold_cnt - 16'h0001;
        else if (s_reg.retard > s_reg.cfg.fall)
          ret = {1'b0, s_reg.retard - s_reg.cfg.fall};
        else
          ret = 17'h0_0000;
      end
    end
    if (ret > {1'b0, s_reg.cfg.ceil})
      s_next.retard = s_reg.cfg.ceil;
    else
      s_next.retard = ret[15:0];

    // Interrupt status, set wins over clear
    ev[IRQ_KNOCK] = eval && knock;
    ev[IRQ_DERATE] = eval && knock && at_ceil && !s_reg.flags.derate;
    ev[IRQ_STOP] = eval && stop_hit;
    ev[IRQ_SYNC_FAST] = sync_pulse && !sync_ok;
    s_next.irq_status = (s_reg.irq_status & ~clr) | ev;
  end

  // --------------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------------
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      s_reg <= '0;
      s_reg.cfg.retard_thr <= RST_RETARD_THR;
      s_reg.cfg.stop_thr <= RST_STOP_THR;
      s_reg.cfg.gain <= RST_GAIN;
      s_reg.cfg.fall <= RST_FALL;
      s_reg.cfg.ceil <= RST_CEIL;
      s_reg.cfg.hold <= RST_HOLD;
      s_reg.cfg.win_delay <= RST_WIN_DELAY;
      s_reg.cfg.win_len <= RST_WIN_LEN;
      s_reg.cfg.ch_en <= RST_CH_EN;
    end
    else
      s_reg <= s_next;
  end

  // --------------------------------------------------------------------------
  // Outputs
  // --------------------------------------------------------------------------
  assign avs_readdata = s_reg.rdata;
  assign avs_waitrequest = req && !s_reg.ack;
  assign detonation_flag = s_reg.flags.detonation;
  assign derate_request = s_reg.flags.derate;
  assign emergency_stop_flag = s_reg.flags.stop;
  assign retard_value = s_reg.retard;
  assign irq = |(s_reg.irq_status & s_reg.irq_mask);

  // --------------------------------------------------------------------------
  // Assertions
  // --------------------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_knock_eval;
    eval && knock;
  endsequence

  sequence s_release;
    eval && !knock && derate_request;
  endsequence

  property p_knock_flag;
    eval |=> (detonation_flag == ($past(peak) >= $past(s_reg.cfg.retard_thr)));
  endproperty
  a_knock_flag: assert property (p_knock_flag)
    else $error("Detonation flag does not match level comparison");

  property p_rise;
    s_knock_eval ##0 (rise_sum <= {1'b0, s_reg.cfg.ceil})
      |=> retard_value == $past(rise_sum[15:0]);
  endproperty
  a_rise: assert property (p_rise)
    else $error("Retard did not rise by the gain");

  property p_fall;
    eval && !knock && !derate_request && s_reg.hold_cnt == 16'h0000
      && retard_value >= s_reg.cfg.fall
      |=> retard_value == $past(retard_value) - $past(s_reg.cfg.fall);
  endproperty
  a_fall: assert property (p_fall)
    else $error("Retard did not fall by the fall rate");

  property p_ceiling;
    retard_value <= $past(s_reg.cfg.ceil);
  endproperty
  a_ceiling: assert property (p_ceiling)
    else $error("Retard above ceiling");

  property p_derate_on;
    s_knock_eval ##0 (retard_value >= s_reg.cfg.ceil) |=> derate_request;
  endproperty
  a_derate_on: assert property (p_derate_on)
    else $error("Derate not raised at ceiling while knocking");

  property p_derate_off;
    eval && !knock |=> !derate_request;
  endproperty
  a_derate_off: assert property (p_derate_off)
    else $error("Derate still set after knocking stopped");

  property p_hold;
    s_release |=> (s_reg.hold_cnt == $past(s_reg.cfg.hold))
                  && (retard_value == $past(retard_value));
  endproperty
  a_hold: assert property (p_hold)
    else $error("Retard not held after derate release");

  property p_stop;
    eval |=> (emergency_stop_flag == ($past(peak) > $past(s_reg.cfg.stop_thr)));
  endproperty
  a_stop: assert property (p_stop)
    else $error("Emergency stop does not match stop threshold");

  property p_not_started;
    !s_reg.started |-> !detonation_flag && !derate_request && !emergency_stop_flag
                       && retard_value == 16'h0000;
  endproperty
  a_not_started: assert property (p_not_started)
    else $error("Outputs active before first sync");

  property p_fast_sync;
    sync_pulse && s_reg.started && s_reg.sync_cnt < MIN_SYNC_CYCLES - 17'd1 |-> !eval;
  endproperty
  a_fast_sync: assert property (p_fast_sync)
    else $error("Evaluation on a too-early sync");

  property p_once_per_cycle;
    eval |=> !eval;
  endproperty
  a_once_per_cycle: assert property (p_once_per_cycle)
    else $error("Two evaluations back to back");

endmodule // klsup_top

// ### klsup_engine_model.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Sync source and measurement stage model
// ----------------------------------------------------------------------------
module klsup_engine_model
  import klsup_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic fire,
  input wire logic [15:0] lvl,
  input wire logic [4:0] ch,
  input wire logic [3:0] at,
  output logic sync_pulse,
  output klsup_meas_s meas
);
  logic [3:0] idx_reg;
  logic hit;

  // Sample lands at offset at from the sync cycle, 0 is the sync cycle
  assign hit = fire ? (at == 4'h0) : (idx_reg != 4'h0 && idx_reg == at);

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      idx_reg <= 4'h0;
      sync_pulse <= 1'b0;
      meas <= '0;
    end
    else
    begin
      sync_pulse <= fire;
      meas.valid <= hit;
      meas.channel <= ch;
      // Idle level toggles so a stale sample is never repeated
      meas.level <= hit ? lvl : ~meas.level;
      if (fire)
        idx_reg <= 4'h1;
      else if (idx_reg != 4'h0 && idx_reg != 4'hF)
        idx_reg <= idx_reg + 4'h1;
    end
  end
endmodule // klsup_engine_model

// ### test_knock_level_supervisor.sv
`timescale 1ns/1ps
module test_knock_level_supervisor
  import klsup_pkg::*;
;
  logic clk;
  logic reset_n;
  logic [5:0] avs_address;
  logic avs_read;
  logic avs_write;
  logic [31:0] avs_writedata;
  logic [3:0] avs_byteenable;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic sync_pulse;
  klsup_meas_s meas;
  logic detonation_flag;
  logic derate_request;
  logic emergency_stop_flag;
  logic [15:0] retard_value;
  logic irq;
  logic fire;
  logic [15:0] lvl;
  logic [4:0] ch;
  logic [3:0] at;
  int mismatches;
  int check_count;

  // --------------------------------------------------------------------------
  // Instances
  // --------------------------------------------------------------------------
  klsup_top #(.NUM_CH(2), .MIN_SYNC_CYCLES(17'h0_0014)) i_dut (
    .clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .sync_pulse(sync_pulse), .meas(meas), .detonation_flag(detonation_flag),
    .derate_request(derate_request), .emergency_stop_flag(emergency_stop_flag),
    .retard_value(retard_value), .irq(irq)
  );

  klsup_engine_model i_model (
    .clk(clk), .reset_n(reset_n), .fire(fire), .lvl(lvl), .ch(ch), .at(at),
    .sync_pulse(sync_pulse), .meas(meas)
  );

  // --------------------------------------------------------------------------
  // Helpers
  // --------------------------------------------------------------------------
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check_val(input string what, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic bus(input logic is_rd, input logic [5:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    int n;
    @(posedge clk);
    avs_read <= is_rd;
    avs_write <= !is_rd;
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    for (n = 0; n < 50; n++)
    begin
      @(posedge clk);
      if (avs_waitrequest === 1'b0)
        break;
    end
    if (n == 50)
    begin
      mismatches++;
      report_and_stop();
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
    logic [31:0] q;
    bus(1'b0, a, d, be, q);
  endtask

  task automatic rd(input logic [5:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b1, a, 32'h0000_0000, 4'h0, q);
    check_val($sformatf("reg %h", a), exp, q);
  endtask

  // One combustion frame, then the outputs of the evaluation it triggered
  task automatic sc(input logic [15:0] l, input logic [3:0] a, input logic [4:0] c,
                    input logic d, input logic r, input logic s, input logic [15:0] ret);
    @(posedge clk);
    lvl <= l;
    at <= a;
    ch <= c;
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (25) @(posedge clk);
    check_val("detonation", d, detonation_flag);
    check_val("derate", r, derate_request);
    check_val("stop", s, emergency_stop_flag);
    check_val("retard", ret, retard_value);
  endtask

  // --------------------------------------------------------------------------
  // Scenarios
  // --------------------------------------------------------------------------
  task automatic t_regs();
    rd(OFF_RETARD_THR, 32'h0000_8000);
    rd(OFF_STOP_THR, 32'h0000_C000);
    rd(OFF_CH_EN, 32'h000F_FFFF);
    rd(OFF_IRQ_MASK, 32'h0000_0000);
    wr(OFF_HOLD, 32'h0000_5502, 4'h1);
    rd(OFF_HOLD, 32'h0000_0002);
    wr(OFF_CEIL, 32'h0000_0030, 4'hF);
    wr(OFF_IRQ_MASK, 32'h0000_000F, 4'hF);
    wr(6'h3C, 32'h0000_1234, 4'hF);
    rd(6'h3C, 32'h0000_0000);
    $display("register test done");
  endtask

  task automatic t_ramp();
    sc(16'h8000, 4'h3, 5'h00, 1'b0, 1'b0, 1'b0, 16'h0000);
    sc(16'h8000, 4'h3, 5'h00, 1'b1, 1'b0, 1'b0, 16'h0010);
    sc(16'hC000, 4'h3, 5'h00, 1'b1, 1'b0, 1'b0, 16'h0020);
    sc(16'hC001, 4'h3, 5'h00, 1'b1, 1'b0, 1'b0, 16'h0030);
    sc(16'h7FFF, 4'h3, 5'h00, 1'b1, 1'b1, 1'b1, 16'h0030);
    rd(OFF_LEVEL, 32'h0000_C001);
    rd(OFF_FLAGS, 32'h0000_000F);
    $display("ramp test done");
  endtask

  task automatic t_hold();
    sc(16'h7FFF, 4'h3, 5'h00, 1'b0, 1'b0, 1'b0, 16'h0030);
    rd(OFF_FLAGS, 32'h0000_0018);
    sc(16'h7FFF, 4'h3, 5'h00, 1'b0, 1'b0, 1'b0, 16'h0030);
    sc(16'h7FFF, 4'h3, 5'h00, 1'b0, 1'b0, 1'b0, 16'h0030);
    sc(16'h7FFF, 4'h3, 5'h00, 1'b0, 1'b0, 1'b0, 16'h002C);
    $display("hold test done");
  endtask

  task automatic t_ignore();
    sc(16'hFFFF, 4'h0, 5'h00, 1'b0, 1'b0, 1'b0, 16'h0028);
    sc(16'hFFFF, 4'h3, 5'h03, 1'b0, 1'b0, 1'b0, 16'h0024);
    sc(16'hFFFF, 4'h3, 5'h01, 1'b0, 1'b0, 1'b0, 16'h0020);
    wr(OFF_WIN_LEN, 32'h0000_0002, 4'hF);
    sc(16'hFFFF, 4'hA, 5'h00, 1'b1, 1'b0, 1'b1, 16'h0030);
    sc(16'h0000, 4'h1, 5'h00, 1'b0, 1'b0, 1'b0, 16'h002C);
    rd(OFF_RETARD, 32'h0000_002C);
    wr(OFF_RETARD, 32'h0000_FFFF, 4'hF);
    rd(OFF_RETARD, 32'h0000_002C);
    $display("ignore test done");
  endtask

  task automatic t_irq();
    rd(OFF_IRQ_STATUS, 32'h0000_0007);
    check_val("irq", 1'b1, irq);
    wr(OFF_IRQ_MASK, 32'h0000_0000, 4'hF);
    @(posedge clk);
    check_val("irq", 1'b0, irq);
    wr(OFF_IRQ_MASK, 32'h0000_000F, 4'hF);
    @(posedge clk);
    check_val("irq", 1'b1, irq);
    wr(OFF_IRQ_STATUS, 32'h0000_0007, 4'hF);
    rd(OFF_IRQ_STATUS, 32'h0000_0000);
    check_val("irq", 1'b0, irq);
    // Accepted sync, then a second one far too soon
    @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (4) @(posedge clk);
    fire <= 1'b1;
    @(posedge clk);
    fire <= 1'b0;
    repeat (3) @(posedge clk);
    rd(OFF_IRQ_STATUS, 32'h0000_0008);
    check_val("irq", 1'b1, irq);
    check_val("retard", 32'h0000_0028, retard_value);
    $display("interrupt test done");
  endtask

  // --------------------------------------------------------------------------
  // Main sequence
  // --------------------------------------------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    mismatches = 0;
    check_count = 0;
    reset_n = 1'b0;
    avs_address = 6'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    fire = 1'b0;
    lvl = 16'h0000;
    ch = 5'h00;
    at = 4'h3;
    repeat (6) @(posedge clk);
    reset_n <= 1'b1;
    t_regs();
    t_ramp();
    t_hold();
    t_ignore();
    t_irq();
    report_and_stop();
  end
endmodule // test_knock_level_supervisor
